// File: logic/diag_regs_pkg.sv
package diag_regs_pkg;
    // ==========================================================
    // Time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 100000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_MS  = 1000000 / TICK_NS;
    localparam int WINDOW_MS [8] = '{0, 2, 4, 6, 10, 20, 50, 100};
    localparam int BLANK_US  [4] = '{400, 1000, 2000, 4000};
    localparam int WINDOW_W      = 10;
    localparam int BLANK_W       = 6;

    // ==========================================================
    // Register map
    localparam logic [7:0]  OFF_LIMIT = 8'h0f;
    localparam logic [7:0]  OFF_DIAG  = 8'h10;
    localparam logic [7:0]  OFF_CUR   = 8'h11;
    localparam logic [7:0]  OFF_TEMP  = 8'h12;
    localparam logic [15:0] RST_LIMIT = 16'h0088;
    localparam logic [15:0] RST_DIAG  = 16'hc002;
    localparam logic [3:0]  TRIP_MAX_CODE = 4'hc;

    // ==========================================================
    // Field positions
    localparam int F_STEADY_LO = 0;
    localparam int F_SURGE_LO  = 4;
    localparam int F_WINDOW_LO = 8;
    localparam int B_VOLT_OFF  = 15;
    localparam int B_TEMP_OFF  = 14;
    localparam int B_CUR_OFF   = 13;
    localparam int B_GAIN      = 10;
    localparam int B_ON_OL     = 9;
    localparam int F_BLANK_LO  = 7;
    localparam int F_PULL_LO   = 5;
    localparam int B_OFF_OL    = 4;
    localparam int B_BSHORT    = 3;
    localparam int B_HOLD      = 2;
    localparam int F_EDGE_LO   = 0;
    localparam int B_FRESH     = 10;
    localparam int SAMPLE_W    = 10;
endpackage

// File: logic/blank_filter.sv
`timescale 1ns/1ps
module blank_filter (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic       tick_i,
    input  wire logic       raw_i,
    input  wire logic [1:0] blank_sel_i,
    output logic            fault_o
);
    localparam int BW = diag_regs_pkg::BLANK_W;

    // ==========================================================
    // Persistence counter
    logic [diag_regs_pkg::BLANK_W-1:0] count;
    logic [diag_regs_pkg::BLANK_W-1:0] next_count;
    logic [diag_regs_pkg::BLANK_W-1:0] limit;
    logic                              next_fault;

    // A glitch shorter than the blanking time restarts the count
    always_comb begin
        limit      = BW'(diag_regs_pkg::BLANK_US[blank_sel_i] * 1000
                     / diag_regs_pkg::TICK_NS);
        next_count = count;
        next_fault = fault_o;
        if (!raw_i) begin
            next_count = '0;
            next_fault = 1'b0;
        end else if (tick_i && count != limit) begin
            next_count = count + 1'b1;
        end
        if (raw_i && next_count == limit) begin
            next_fault = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count   <= '0;
            fault_o <= 1'b0;
        end else if (ce_i) begin
            count   <= next_count;
            fault_o <= next_fault;
        end
    end

    // ==========================================================
    // Checks
    property p_blank_full;
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(fault_o) |-> $past(raw_i) && count == limit;
    endproperty
    a_blank_full: assert property (p_blank_full) else $error("fault before blanking");
    c_blank_fault: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(fault_o));
endmodule

// File: logic/sample_holder.sv
`timescale 1ns/1ps
module sample_holder (
    input  wire logic                                clk_i,
    input  wire logic                                nrst_i,
    input  wire logic                                ce_i,
    input  wire logic                                load_i,
    input  wire logic [diag_regs_pkg::SAMPLE_W-1:0] data_i,
    input  wire logic                                read_i,
    output logic      [15:0]                        word_o
);
    // ==========================================================
    // Result and freshness
    logic [diag_regs_pkg::SAMPLE_W-1:0] value;
    logic [diag_regs_pkg::SAMPLE_W-1:0] next_value;
    logic                               fresh;
    logic                               next_fresh;

    // A conversion landing with a read keeps the flag set, so it is never lost
    always_comb begin
        next_value = value;
        next_fresh = fresh;
        if (read_i) begin
            next_fresh = 1'b0;
        end
        if (load_i) begin
            next_value = data_i;
            next_fresh = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            value <= '0;
            fresh <= 1'b0;
        end else if (ce_i) begin
            value <= next_value;
            fresh <= next_fresh;
        end
    end

    // Upper bits are hard zero
    assign word_o = {5'h00, fresh, value};
endmodule

// File: logic/channel_one_regs.sv
`timescale 1ns/1ps
module channel_one_regs #(
    parameter int unsigned TICK_CYCLES = diag_regs_pkg::TICK_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic       chan_on_i,
    input  wire logic       chan_fault_i,
    input  wire logic       shutdown_fault_i,
    input  wire logic       switch_cmd_write_i,
    input  wire logic       cur_conv_valid_i,
    input  wire logic [9:0] cur_conv_data_i,
    input  wire logic       temp_conv_valid_i,
    input  wire logic [9:0] temp_conv_data_i,
    input  wire logic       open_load_raw_i,
    input  wire logic       batt_short_raw_i,
    output logic      [3:0] trip_level_code_o,
    output logic            trip_code_ok_o,
    output logic            surge_active_o,
    output logic            voltage_meas_off_o,
    output logic            temp_meas_off_o,
    output logic            current_meas_off_o,
    output logic            current_gain_x8_o,
    output logic            on_open_load_check_o,
    output logic      [1:0] off_pullup_strength_o,
    output logic            off_open_load_check_o,
    output logic            battery_short_check_o,
    output logic            open_load_fault_o,
    output logic            battery_short_fault_o,
    output logic            latched_off_o,
    output logic      [1:0] output_edge_rate_o
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int WW = diag_regs_pkg::WINDOW_W;

    // ==========================================================
    // 0.1 ms tick
    logic [TW-1:0] tick_cnt;
    logic [TW-1:0] next_tick_cnt;
    logic          tick;
    logic          next_tick;

    // Shared prescaler keeps the long timers narrow
    always_comb begin
        next_tick_cnt = tick_cnt + 1'b1;
        next_tick     = 1'b0;
        if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
            next_tick_cnt = '0;
            next_tick     = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (ce_i) begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
        end
    end

    // ==========================================================
    // Configuration registers
    logic [15:0] limit_cfg;
    logic [15:0] next_limit_cfg;
    logic [15:0] diag_setup;
    logic [15:0] next_diag_setup;
    logic        wr_limit;
    logic        wr_diag;
    logic        rd_cur;
    logic        rd_temp;

    // Address decode of the strobes
    assign wr_limit = reg_wr_i && reg_addr_i == diag_regs_pkg::OFF_LIMIT;
    assign wr_diag  = reg_wr_i && reg_addr_i == diag_regs_pkg::OFF_DIAG;
    assign rd_cur   = reg_rd_i && reg_addr_i == diag_regs_pkg::OFF_CUR;
    assign rd_temp  = reg_rd_i && reg_addr_i == diag_regs_pkg::OFF_TEMP;

    // Off-state checks are refused at write time, not silently dropped later
    always_comb begin
        next_limit_cfg = limit_cfg;
        next_diag_setup = diag_setup;
        if (wr_limit) begin
            next_limit_cfg = reg_wdata_i;
        end
        if (wr_diag) begin
            next_diag_setup = reg_wdata_i;
            if (chan_on_i || chan_fault_i) begin
                next_diag_setup[diag_regs_pkg::B_OFF_OL] = 1'b0;
                next_diag_setup[diag_regs_pkg::B_BSHORT] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            limit_cfg  <= diag_regs_pkg::RST_LIMIT;
            diag_setup <= diag_regs_pkg::RST_DIAG;
        end else if (ce_i) begin
            limit_cfg  <= next_limit_cfg;
            diag_setup <= next_diag_setup;
        end
    end

    // Configuration bits drive the analog side directly
    assign voltage_meas_off_o    = diag_setup[diag_regs_pkg::B_VOLT_OFF];
    assign temp_meas_off_o       = diag_setup[diag_regs_pkg::B_TEMP_OFF];
    assign current_meas_off_o    = diag_setup[diag_regs_pkg::B_CUR_OFF];
    assign current_gain_x8_o     = diag_setup[diag_regs_pkg::B_GAIN];
    assign on_open_load_check_o  = diag_setup[diag_regs_pkg::B_ON_OL];
    assign off_pullup_strength_o = diag_setup[diag_regs_pkg::F_PULL_LO +: 2];
    assign off_open_load_check_o = diag_setup[diag_regs_pkg::B_OFF_OL];
    assign battery_short_check_o = diag_setup[diag_regs_pkg::B_BSHORT];
    assign output_edge_rate_o    = diag_setup[diag_regs_pkg::F_EDGE_LO +: 2];

    // ==========================================================
    // Surge window and trip level
    logic          chan_on_q;
    logic [WW-1:0] surge_count;
    logic [WW-1:0] next_surge_count;
    logic [3:0]    next_trip_code;
    logic [2:0]    window_code;

    function automatic logic [WW-1:0] window_ticks(input logic [2:0] code);
        return WW'(diag_regs_pkg::WINDOW_MS[code] * diag_regs_pkg::TICKS_PER_MS);
    endfunction

    // Window restarts on every turn-on edge and ends early when switched off
    always_comb begin
        window_code      = limit_cfg[diag_regs_pkg::F_WINDOW_LO +: 3];
        next_surge_count = surge_count;
        if (chan_on_i && !chan_on_q) begin
            next_surge_count = window_ticks(window_code);
        end else if (!chan_on_i) begin
            next_surge_count = '0;
        end else if (tick && surge_count != '0) begin
            next_surge_count = surge_count - 1'b1;
        end
        next_trip_code = (next_surge_count != '0) ?
                         limit_cfg[diag_regs_pkg::F_SURGE_LO +: 4] :
                         limit_cfg[diag_regs_pkg::F_STEADY_LO +: 4];
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chan_on_q         <= 1'b0;
            surge_count       <= '0;
            surge_active_o    <= 1'b0;
            trip_level_code_o <= 4'h0;
            trip_code_ok_o    <= 1'b0;
        end else if (ce_i) begin
            chan_on_q         <= chan_on_i;
            surge_count       <= next_surge_count;
            surge_active_o    <= next_surge_count != '0;
            trip_level_code_o <= next_trip_code;
            trip_code_ok_o    <= next_trip_code <= diag_regs_pkg::TRIP_MAX_CODE;
        end
    end

    // ==========================================================
    // Fault reaction
    logic next_latched;

    // A new shutdown beats a command write in the same cycle
    always_comb begin
        next_latched = latched_off_o;
        if (switch_cmd_write_i) begin
            next_latched = 1'b0;
        end
        if (shutdown_fault_i && diag_setup[diag_regs_pkg::B_HOLD]) begin
            next_latched = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            latched_off_o <= 1'b0;
        end else if (ce_i) begin
            latched_off_o <= next_latched;
        end
    end

    // ==========================================================
    // Blanking filters and sample holders, one per lane
    logic [1:0]  raw_bus;
    logic [1:0]  flag_bus;
    logic [1:0]  load_bus;
    logic [1:0]  read_bus;
    logic [9:0]  data_bus [2];
    logic [15:0] word_bus [2];

    assign raw_bus     = {batt_short_raw_i, open_load_raw_i};
    assign load_bus    = {temp_conv_valid_i, cur_conv_valid_i};
    assign read_bus    = {rd_temp, rd_cur};
    assign data_bus[0] = cur_conv_data_i;
    assign data_bus[1] = temp_conv_data_i;

    for (genvar gi = 0; gi < 2; gi++) begin : g_lane
        blank_filter u_blank (
            .clk_i       (clk_i),
            .nrst_i      (nrst_i),
            .ce_i        (ce_i),
            .tick_i      (tick),
            .raw_i       (raw_bus[gi]),
            .blank_sel_i (diag_setup[diag_regs_pkg::F_BLANK_LO +: 2]),
            .fault_o     (flag_bus[gi])
        );
        sample_holder u_sample (
            .clk_i  (clk_i),
            .nrst_i (nrst_i),
            .ce_i   (ce_i),
            .load_i (load_bus[gi]),
            .data_i (data_bus[gi]),
            .read_i (read_bus[gi]),
            .word_o (word_bus[gi])
        );
    end

    assign open_load_fault_o     = flag_bus[0];
    assign battery_short_fault_o = flag_bus[1];

    // ==========================================================
    // Read port
    logic [15:0] next_rdata;

    // Unmapped reads answer zero; data holds until the next read
    always_comb begin
        next_rdata = reg_rdata_o;
        if (reg_rd_i) begin
            case (reg_addr_i)
                diag_regs_pkg::OFF_LIMIT: next_rdata = limit_cfg;
                diag_regs_pkg::OFF_DIAG:  next_rdata = diag_setup;
                diag_regs_pkg::OFF_CUR:   next_rdata = word_bus[0];
                diag_regs_pkg::OFF_TEMP:  next_rdata = word_bus[1];
                default:                  next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (ce_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_steady_trip;
        ce_i && next_surge_count == '0 |=>
            !surge_active_o && trip_level_code_o == $past(limit_cfg[3:0]);
    endproperty
    a_steady_trip: assert property (p_steady_trip) else $error("steady code not applied");

    property p_volt_off;
        ce_i && wr_diag |=> voltage_meas_off_o == $past(reg_wdata_i[15]);
    endproperty
    a_volt_off: assert property (p_volt_off) else $error("voltage off bit wrong");

    property p_cur_off;
        ce_i && wr_diag |=> current_meas_off_o == $past(reg_wdata_i[13]);
    endproperty
    a_cur_off: assert property (p_cur_off) else $error("current off bit wrong");

    property p_pullup_refused;
        ce_i && wr_diag && (chan_on_i || chan_fault_i) |=> !off_open_load_check_o;
    endproperty
    a_pullup_refused: assert property (p_pullup_refused) else $error("pull-up check accepted");

    property p_bshort_refused;
        ce_i && wr_diag && (chan_on_i || chan_fault_i) |=> !battery_short_check_o;
    endproperty
    a_bshort_refused: assert property (p_bshort_refused) else $error("short check accepted");

    property p_latch_set;
        ce_i && shutdown_fault_i && diag_setup[2] |=> latched_off_o;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch not set");

    property p_latch_hold;
        latched_off_o && ce_i && !switch_cmd_write_i |=> latched_off_o;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch released early");

    property p_edge_rate;
        ce_i && wr_diag |=> output_edge_rate_o == $past(reg_wdata_i[1:0]);
    endproperty
    a_edge_rate: assert property (p_edge_rate) else $error("edge rate wrong");

    property p_cur_store;
        ce_i && cur_conv_valid_i |=> word_bus[0][10:0] == {1'b1, $past(cur_conv_data_i)};
    endproperty
    a_cur_store: assert property (p_cur_store) else $error("current sample lost");

    property p_read_clears;
        ce_i && rd_cur && !cur_conv_valid_i |=> !word_bus[0][10];
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("fresh flag kept");

    property p_reserved_zero;
        ce_i && (rd_cur || rd_temp) |=> reg_rdata_o[15:11] == 5'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_window_start;
        ce_i && chan_on_i && !chan_on_q && limit_cfg[10:8] != 3'h0 |=> surge_active_o;
    endproperty
    a_window_start: assert property (p_window_start) else $error("surge window missing");

    c_latched: cover property (ce_i && shutdown_fault_i && diag_setup[2] ##1 latched_off_o);
    c_window: cover property ($fell(surge_active_o) && chan_on_i);
    c_fresh_read: cover property (rd_cur && word_bus[0][10]);
endmodule

// File: sim/host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side of the register strobe port
module host_model (
    input  wire logic        clk_i,
    output logic      [7:0]  addr_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [15:0] wdata_o,
    input  wire logic [15:0] rdata_i
);
    // Released lines show the inverse of the last value, so stale data never matches
    initial begin
        addr_o  = 8'hff;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 16'hffff;
    end
    // Strobe held across exactly one rising edge; caller enters just after an edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_o  = a;
        wdata_o = d;
        wr_o    = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o    = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
        @(posedge clk_i);
        #1;
    endtask
    // Read data is taken one edge after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        addr_o = a;
        rd_o   = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o   = 1'b0;
        addr_o = ~a;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [1:0]  cond;
        logic [15:0] w;
        logic [15:0] e;
    } row_t;
    logic clk_i = 1'b0, nrst_i = 1'b0, on = 1'b0, flt = 1'b0, sd = 1'b0, swc = 1'b0;
    logic cv = 1'b0, tv = 1'b0, olr = 1'b0, bsr = 1'b0, wr, rd, sa, ok, lo, olf, bsf;
    logic [9:0] cd = 10'h000, td = 10'h000;
    logic [7:0] addr;
    logic [15:0] wd, rdat, v;
    logic [3:0] tc;
    wire  [10:0] cfg;
    logic        ce = 1'b1;
    int miscompares = 0, comparisons = 0, n;
    row_t rows [8] = '{'{2'b00, 16'h0000, 16'h0000}, '{2'b00, 16'h00a1, 16'h00a1},
        '{2'b00, 16'h0142, 16'h0142}, '{2'b00, 16'h01e3, 16'h01e3},
        '{2'b00, 16'hffff, 16'hffff}, '{2'b10, 16'hffff, 16'hffe7},
        '{2'b01, 16'h0018, 16'h0000}, '{2'b00, 16'h5a5a, 16'h5a5a}};
    always #5 clk_i = ~clk_i;
    // ==========================================================
    // Device and host
    host_model host_model_i (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wd), .rdata_i(rdat));
    channel_one_regs #(.TICK_CYCLES(10)) channel_one_regs_i (.clk_i(clk_i),
        .nrst_i(nrst_i), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wd), .reg_rdata_o(rdat), .chan_on_i(on), .chan_fault_i(flt),
        .shutdown_fault_i(sd), .switch_cmd_write_i(swc), .cur_conv_valid_i(cv),
        .cur_conv_data_i(cd), .temp_conv_valid_i(tv), .temp_conv_data_i(td),
        .open_load_raw_i(olr), .batt_short_raw_i(bsr), .trip_level_code_o(tc),
        .trip_code_ok_o(ok), .surge_active_o(sa), .voltage_meas_off_o(cfg[10]),
        .temp_meas_off_o(cfg[9]), .current_meas_off_o(cfg[8]),
        .current_gain_x8_o(cfg[7]), .on_open_load_check_o(cfg[6]),
        .off_pullup_strength_o(cfg[5:4]), .off_open_load_check_o(cfg[3]),
        .battery_short_check_o(cfg[2]), .open_load_fault_o(olf),
        .battery_short_fault_o(bsf), .latched_off_o(lo), .output_edge_rate_o(cfg[1:0]));
    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog well beyond the roughly 1200 cycles the sequence needs
    initial begin
        #200000;
        miscompares++;
        results();
    end
    // ==========================================================
    // Main sequence
    initial begin
        cyc(12);
        nrst_i = 1'b1;
        cyc(2);
        host_model_i.rd(8'h10, v);
        chk("diag reset", v, 16'hc002);
        host_model_i.rd(8'h0f, v);
        chk("limit reset", v, 16'h0088);
        chk("steady code reset", {12'h000, tc}, 16'h0008);
        host_model_i.rd(8'h11, v);
        chk("current reset", v, 16'h0000);
        host_model_i.rd(8'h12, v);
        chk("temp reset", v, 16'h0000);
        // Table of diag writes with the channel off, on and in fault
        foreach (rows[i]) begin
            {on, flt} = rows[i].cond;
            host_model_i.wr(8'h10, rows[i].w);
            {on, flt} = 2'b00;
            host_model_i.rd(8'h10, v);
            chk("diag readback", v, rows[i].e);
            chk("diag outputs", {5'h00, cfg}, {5'h00, rows[i].e[15:13], rows[i].e[10:9],
                rows[i].e[6:3], rows[i].e[1:0]});
        end
        // Clock enable low freezes the registers, so this write is lost
        ce = 1'b0;
        host_model_i.wr(8'h10, 16'h0000);
        ce = 1'b1;
        host_model_i.rd(8'h10, v);
        chk("frozen diag", v, 16'h5a5a);
        // Host keeps steady codes within 0h..Ch
        for (int c = 0; c <= 12; c++) begin
            host_model_i.wr(8'h0f, 16'(c));
            chk("steady code", {11'h000, ok, tc}, 16'(c) | 16'h0010);
        end
        // Conversions, freshness and read-only sample words
        cv = 1'b1;
        cd = 10'h3ff;
        tv = 1'b1;
        td = 10'h155;
        cyc(1);
        {cv, tv, cd, td} = {2'b00, 10'h000, 10'h2aa};
        host_model_i.rd(8'h11, v);
        chk("current fresh", v, 16'h07ff);
        host_model_i.rd(8'h11, v);
        chk("current stale", v, 16'h03ff);
        host_model_i.wr(8'h12, 16'hffff);
        host_model_i.rd(8'h12, v);
        chk("temp fresh", v, 16'h0555);
        host_model_i.rd(8'h12, v);
        chk("temp stale", v, 16'h0155);
        host_model_i.wr(8'h20, 16'hffff);
        host_model_i.rd(8'h20, v);
        chk("unmapped", v, 16'h0000);
        // Blanking for every code, both fault kinds
        for (int b = 0; b < 4; b++) begin
            host_model_i.wr(8'h10, 16'(b) << 7);
            n = diag_regs_pkg::BLANK_US[b] / 100 * 10;
            {olr, bsr} = 2'b11;
            cyc(n - 12);
            chk("blank early", {14'h0000, olf, bsf}, 16'h0000);
            cyc(24);
            chk("blank late", {14'h0000, olf, bsf}, 16'h0003);
            {olr, bsr} = 2'b00;
            cyc(2);
            chk("blank drop", {14'h0000, olf, bsf}, 16'h0000);
        end
        // Latch off versus auto retry
        for (int h = 1; h >= 0; h--) begin
            host_model_i.wr(8'h10, 16'(h) << 2);
            sd = 1'b1;
            cyc(1);
            sd = 1'b0;
            cyc(2);
            chk("latched", {15'h0000, lo}, 16'(h));
            // A shutdown landing with a command write keeps the channel held
            {sd, swc} = 2'b11;
            cyc(1);
            {sd, swc} = 2'b00;
            cyc(2);
            chk("set wins", {15'h0000, lo}, 16'(h));
            swc = 1'b1;
            cyc(1);
            swc = 1'b0;
            cyc(2);
            chk("released", {15'h0000, lo}, 16'h0000);
        end
        // Surge window of 2 ms is 20 ticks, then the steady code takes over
        host_model_i.wr(8'h0f, 16'h0135);
        on = 1'b1;
        cyc(4);
        chk("surge on", {11'h000, sa, tc}, 16'h0013);
        cyc(180);
        chk("surge held", {11'h000, sa, tc}, 16'h0013);
        cyc(40);
        chk("surge over", {11'h000, sa, tc}, 16'h0005);
        on = 1'b0;
        cyc(2);
        // Reset in mid-run returns every register and output to its reset value
        nrst_i = 1'b0;
        cyc(2);
        chk("reset outputs", {5'h00, cfg}, 16'h0602);
        chk("reset trip", {10'h000, sa, ok, tc}, 16'h0000);
        chk("reset rdata", rdat, 16'h0000);
        nrst_i = 1'b1;
        cyc(2);
        chk("trip after reset", {10'h000, sa, ok, tc}, 16'h0018);
        host_model_i.rd(8'h0f, v);
        chk("limit after reset", v, 16'h0088);
        results();
    end
endmodule
